// ---- verilog/uart_cfg.svh ----
// Register offsets, field positions, reset values and timing constants of the serial port
`ifndef UART_CFG_SVH
`define UART_CFG_SVH

`define OFF_GENERAL_CONFIG      8'h00
`define OFF_SERIAL_CLOCK_CONFIG 8'h04
`define OFF_SERIAL_CONTROL      8'h08
`define OFF_SERIAL_BUFFER       8'h0c
`define OFF_BAUD_CONTROL        8'h10
`define OFF_BAUD_RELOAD_REG     8'h14
`define OFF_FRAC_DIV_CONTROL    8'h18
`define OFF_FRAC_STEP           8'h1c
`define OFF_FRAC_DIV_RESULT     8'h20

`define BIT_SERIAL_PORT_ENABLE  0
`define BIT_RX_CLOCK_ENABLE     0
`define BIT_TX_CLOCK_ENABLE     1
`define BIT_RX_READY_FLAG       0
`define BIT_TX_DONE_FLAG        1
`define BIT_RX_ENABLE           2
`define BIT_BAUD_ENABLE         0
`define POS_BAUD_PRESCALE_SEL   1
`define BIT_FRAC_DIV_ENABLE     0

`define DATA_BITS               8
`define STOP_BITS               1
`define OVERSAMPLE              16
`define FRAC_MODULUS            256
`define SYS_CLOCK_HZ            12000000

`define RST_BAUD_RELOAD         8'h00
`define RST_FRAC_STEP           8'h00

`endif

// ---- verilog/uart_pkg.sv ----
// Types shared by the serial port design
package uart_pkg;

  typedef struct packed {
    logic       rx_clock_enable;
    logic       tx_clock_enable;
    logic       rx_enable;
    logic       baud_enable;
    logic [2:0] baud_prescale_sel;
    logic       frac_div_enable;
    logic [7:0] baud_reload;
    logic [7:0] frac_step;
  } baud_cfg_type;

  typedef enum logic [2:0] {
    ST_IDLE  = 3'b001,
    ST_START = 3'b010,
    ST_SHIFT = 3'b100
  } line_state_type;

endpackage : uart_pkg

// ---- verilog/half_duplex_uart.sv ----
// Half-duplex serial port with fractional baud generator behind AXI4-Lite
//
// Notes on behaviour
// R1: When enabled, one port pin receives and another transmits.
// R2: Port enable switches off the pulling resistor on the receive pin.
// R3: Software sets pin directions itself; enabling does not change them.
// R4: Half-duplex: no transmit while receiving, no simultaneous send and receive. A start bit and a buffer write in the same idle cycle start both directions.
// R5: One completed received byte is held while the next shifts in.
// R6: Buffer read returns receive buffer; buffer write loads transmit shifter.
// R7: Eight data bits, one stop bit appended by the transmitter.
// R8: Writing the buffer register starts transmission of that byte.
// R9: Transmit-done flag set after full send, held until software clears.
// R10: Receive-ready flag set when a byte is buffered; software clears.
// R11: Baud generator runs from the 12 MHz system clock.
// R12: Prescaler divides system clock by a three-bit selected factor.
// R13: Baud timer counts down, reloading with programmed value on underflow.
// R14: Fractional divider output equals input times step over 256.
// R15: Software programs prescale, reload and step for standard rates.
// R16: Receive and transmit clocks have separate enables gating each direction.
// R17: Receiver accepts frames only while receiver enable is set.
// R18: Baud generator enable shares a register with prescale select.
// R19: Fractional divider runs only while its enable is set.
// R20: A readable result register shows the fractional divider state.
// R21: Line idles high, low start bit, LSB first, one bit per period.
`timescale 1ns/1ps
`include "uart_cfg.svh"

module half_duplex_uart
  import uart_pkg::*;
(
  input  wire logic        aclk,
  input  wire logic        aresetn,
  input  wire logic [7:0]  s_axi_awaddr,
  input  wire logic        s_axi_awvalid,
  output logic             s_axi_awready,
  input  wire logic [31:0] s_axi_wdata,
  input  wire logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_wvalid,
  output logic             s_axi_wready,
  output logic [1:0]       s_axi_bresp,
  output logic             s_axi_bvalid,
  input  wire logic        s_axi_bready,
  input  wire logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_arvalid,
  output logic             s_axi_arready,
  output logic [31:0]      s_axi_rdata,
  output logic [1:0]       s_axi_rresp,
  output logic             s_axi_rvalid,
  input  wire logic        s_axi_rready,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  output logic             rx_pull_disable
);

  // ****************************************
  // Register file
  // ****************************************
  logic         serial_port_enable_q;
  baud_cfg_type cfg_q;
  logic         rx_ready_flag_q;
  logic         tx_done_flag_q;
  logic [7:0]   rx_buffer_q;
  logic [7:0]   frac_acc_q;
  logic         aw_got_q;
  logic         w_got_q;
  logic [7:0]   aw_addr_q;
  logic [31:0]  w_data_q;
  logic [3:0]   w_strb_q;
  logic         rx_set;
  logic         tx_set;
  logic         tx_start;
  logic         wr_fire;
  logic         rd_fire;
  logic         rx_busy;
  logic         tx_busy;

  assign wr_fire = aw_got_q && w_got_q && !s_axi_bvalid;
  assign rd_fire = s_axi_arvalid && s_axi_arready;

  function automatic logic known_addr(input logic [7:0] a);
    known_addr = (a <= `OFF_FRAC_DIV_RESULT) && (a[1:0] == 2'b00);
  endfunction : known_addr

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      aw_got_q      <= 1'b0;
      w_got_q       <= 1'b0;
      aw_addr_q     <= 8'h00;
      w_data_q      <= 32'h0000_0000;
      w_strb_q      <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= 2'b00;
    end
    else
    begin
      s_axi_awready <= !aw_got_q && !s_axi_awready && s_axi_awvalid;
      s_axi_wready  <= !w_got_q && !s_axi_wready && s_axi_wvalid;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_got_q  <= 1'b1;
        aw_addr_q <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_got_q  <= 1'b1;
        w_data_q <= s_axi_wdata;
        w_strb_q <= s_axi_wstrb;
      end
      if (wr_fire)
      begin
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= known_addr(aw_addr_q) ? 2'b00 : 2'b10;
      end
      else if (s_axi_bvalid && s_axi_bready)
      begin
        s_axi_bvalid <= 1'b0;
        aw_got_q     <= 1'b0;
        w_got_q      <= 1'b0;
      end
    end
  end

  // Only byte lane 0 carries register data
  assign tx_start = wr_fire && w_strb_q[0] && aw_addr_q == `OFF_SERIAL_BUFFER
                    && cfg_q.tx_clock_enable && !rx_busy && !tx_busy; // R8 R4 R16

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      serial_port_enable_q <= 1'b0;
      cfg_q                <= '{default: '0, baud_reload: `RST_BAUD_RELOAD,
                                frac_step: `RST_FRAC_STEP};
    end
    else if (wr_fire && w_strb_q[0])
    begin
      unique case (aw_addr_q)
        `OFF_GENERAL_CONFIG:
          serial_port_enable_q <= w_data_q[`BIT_SERIAL_PORT_ENABLE];
        `OFF_SERIAL_CLOCK_CONFIG:
        begin
          cfg_q.rx_clock_enable <= w_data_q[`BIT_RX_CLOCK_ENABLE]; // R16
          cfg_q.tx_clock_enable <= w_data_q[`BIT_TX_CLOCK_ENABLE]; // R16
        end
        `OFF_SERIAL_CONTROL:
          cfg_q.rx_enable <= w_data_q[`BIT_RX_ENABLE];
        `OFF_BAUD_CONTROL:
        begin
          cfg_q.baud_enable       <= w_data_q[`BIT_BAUD_ENABLE]; // R18
          cfg_q.baud_prescale_sel <= w_data_q[`POS_BAUD_PRESCALE_SEL +: 3]; // R18
        end
        `OFF_BAUD_RELOAD_REG:
          cfg_q.baud_reload <= w_data_q[7:0];
        `OFF_FRAC_DIV_CONTROL:
          cfg_q.frac_div_enable <= w_data_q[`BIT_FRAC_DIV_ENABLE];
        `OFF_FRAC_STEP:
          cfg_q.frac_step <= w_data_q[7:0];
        default:
        begin
        end
      endcase
    end
  end

  // Flags: a hardware set in the clearing cycle wins
  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_ready_flag_q <= 1'b0;
      tx_done_flag_q  <= 1'b0;
    end
    else
    begin
      if (wr_fire && w_strb_q[0] && aw_addr_q == `OFF_SERIAL_CONTROL)
      begin
        rx_ready_flag_q <= w_data_q[`BIT_RX_READY_FLAG] & rx_ready_flag_q; // R10
        tx_done_flag_q  <= w_data_q[`BIT_TX_DONE_FLAG] & tx_done_flag_q; // R9
      end
      if (rx_set)
        rx_ready_flag_q <= 1'b1; // R10
      if (tx_set)
        tx_done_flag_q <= 1'b1; // R9
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= 2'b00;
    end
    else
    begin
      s_axi_arready <= !s_axi_arready && !s_axi_rvalid && s_axi_arvalid;
      if (rd_fire)
      begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= known_addr(s_axi_araddr) ? 2'b00 : 2'b10;
        unique case (s_axi_araddr)
          `OFF_GENERAL_CONFIG:
            s_axi_rdata <= {31'h0, serial_port_enable_q};
          `OFF_SERIAL_CLOCK_CONFIG:
            s_axi_rdata <= {30'h0, cfg_q.tx_clock_enable, cfg_q.rx_clock_enable};
          `OFF_SERIAL_CONTROL:
            s_axi_rdata <= {29'h0, cfg_q.rx_enable, tx_done_flag_q, rx_ready_flag_q};
          `OFF_SERIAL_BUFFER:
            s_axi_rdata <= {24'h0, rx_buffer_q}; // R6
          `OFF_BAUD_CONTROL:
            s_axi_rdata <= {28'h0, cfg_q.baud_prescale_sel, cfg_q.baud_enable};
          `OFF_BAUD_RELOAD_REG:
            s_axi_rdata <= {24'h0, cfg_q.baud_reload};
          `OFF_FRAC_DIV_CONTROL:
            s_axi_rdata <= {31'h0, cfg_q.frac_div_enable};
          `OFF_FRAC_STEP:
            s_axi_rdata <= {24'h0, cfg_q.frac_step};
          `OFF_FRAC_DIV_RESULT:
            s_axi_rdata <= {24'h0, frac_acc_q}; // R20
          default:
            s_axi_rdata <= 32'h0000_0000;
        endcase
      end
      else if (s_axi_rvalid && s_axi_rready)
        s_axi_rvalid <= 1'b0;
    end
  end

  // ****************************************
  // Baud generator: prescaler, reload timer, fractional divider
  // ****************************************
  logic [6:0] pre_cnt_q;
  logic       pre_tick;
  logic [7:0] timer_q;
  logic       timer_tick;
  logic [8:0] frac_sum;
  logic       os_tick;

  // Prescale 2^sel from the system clock
  assign pre_tick = cfg_q.baud_enable &&
                    ((pre_cnt_q & ((7'h01 << cfg_q.baud_prescale_sel) - 7'h01)) == 7'h00); // R12 R11

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cfg_q.baud_enable)
      pre_cnt_q <= 7'h00;
    else
      pre_cnt_q <= pre_cnt_q + 7'h01; // R12
  end

  assign timer_tick = pre_tick && timer_q == 8'h00;

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cfg_q.baud_enable)
      timer_q <= cfg_q.baud_reload;
    else if (pre_tick)
      timer_q <= (timer_q == 8'h00) ? cfg_q.baud_reload : timer_q - 8'h01; // R13
  end

  // Overflow of the phase accumulator gives step/256 of the timer rate
  assign frac_sum = {1'b0, frac_acc_q} + {1'b0, cfg_q.frac_step};
  assign os_tick  = cfg_q.frac_div_enable && timer_tick && frac_sum[8]; // R14 R19

  always_ff @(posedge aclk)
  begin
    if (!aresetn || !cfg_q.frac_div_enable)
      frac_acc_q <= 8'h00; // R19
    else if (timer_tick)
      frac_acc_q <= frac_sum[7:0]; // R14
  end

  // ****************************************
  // Pins
  // ****************************************
  logic rx_meta_q;
  logic rx_sync_q;

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_meta_q       <= 1'b1;
      rx_sync_q       <= 1'b1;
      rx_pull_disable <= 1'b0;
    end
    else
    begin
      rx_meta_q       <= rx_pin; // R1
      rx_sync_q       <= rx_meta_q;
      rx_pull_disable <= serial_port_enable_q; // R2
    end
  end

  // ****************************************
  // Transmitter, 16 ticks per bit
  // ****************************************
  line_state_type tx_state_q;
  logic [7:0]     tx_shift_q;
  logic [3:0]     tx_tick_q;
  logic [3:0]     tx_bit_q;

  assign tx_busy = tx_state_q != ST_IDLE;
  assign tx_set  = tx_state_q == ST_SHIFT && os_tick && cfg_q.tx_clock_enable && tx_tick_q == 4'hf
                   && tx_bit_q == 4'(`DATA_BITS + `STOP_BITS - 1); // R9

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      tx_state_q <= ST_IDLE;
      tx_shift_q <= 8'h00;
      tx_tick_q  <= 4'h0;
      tx_bit_q   <= 4'h0;
      tx_pin     <= 1'b1;
    end
    else
    begin
      unique case (tx_state_q)
        ST_IDLE:
        begin
          tx_pin <= 1'b1; // R21
          if (tx_start && serial_port_enable_q)
          begin
            tx_shift_q <= w_data_q[7:0]; // R6
            tx_tick_q  <= 4'h0;
            tx_state_q <= ST_START;
          end
        end
        ST_START:
        begin
          tx_pin <= 1'b0; // R21
          if (os_tick && cfg_q.tx_clock_enable) // R16
          begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == 4'hf)
            begin
              tx_bit_q   <= 4'h0;
              tx_state_q <= ST_SHIFT;
            end
          end
        end
        ST_SHIFT:
        begin
          // Stop bit shifts in as a one after the data
          tx_pin <= tx_shift_q[0]; // R21 R7
          if (os_tick && cfg_q.tx_clock_enable)
          begin
            tx_tick_q <= tx_tick_q + 4'h1;
            if (tx_tick_q == 4'hf)
            begin
              tx_shift_q <= {1'b1, tx_shift_q[7:1]};
              tx_bit_q   <= tx_bit_q + 4'h1;
              if (tx_set)
                tx_state_q <= ST_IDLE; // R7
            end
          end
        end
        default:
          tx_state_q <= ST_IDLE;
      endcase
    end
  end

  // ****************************************
  // Receiver, samples mid-bit
  // ****************************************
  line_state_type rx_state_q;
  logic [7:0]     rx_shift_q;
  logic [3:0]     rx_tick_q;
  logic [3:0]     rx_bit_q;
  logic           rx_run;

  assign rx_busy = rx_state_q != ST_IDLE;
  assign rx_run  = serial_port_enable_q && cfg_q.rx_enable && cfg_q.rx_clock_enable; // R17 R16
  assign rx_set  = rx_state_q == ST_SHIFT && os_tick && rx_tick_q == 4'hf
                   && rx_bit_q == 4'(`DATA_BITS); // R5

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
    begin
      rx_state_q  <= ST_IDLE;
      rx_shift_q  <= 8'h00;
      rx_tick_q   <= 4'h0;
      rx_bit_q    <= 4'h0;
      rx_buffer_q <= 8'h00;
    end
    else if (!rx_run)
      rx_state_q <= ST_IDLE; // R17
    else
    begin
      unique case (rx_state_q)
        ST_IDLE:
          // No reception while own frame goes out
          if (!rx_sync_q && !tx_busy) // R4
          begin
            rx_tick_q  <= 4'h8;
            rx_state_q <= ST_START;
          end
        ST_START:
          if (os_tick)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == 4'hf)
            begin
              rx_bit_q   <= 4'h0;
              rx_state_q <= rx_sync_q ? ST_IDLE : ST_SHIFT;
            end
          end
        ST_SHIFT:
          if (os_tick)
          begin
            rx_tick_q <= rx_tick_q + 4'h1;
            if (rx_tick_q == 4'hf)
            begin
              rx_bit_q <= rx_bit_q + 4'h1;
              if (rx_bit_q < 4'(`DATA_BITS))
                rx_shift_q <= {rx_sync_q, rx_shift_q[7:1]}; // R21
              if (rx_set)
              begin
                rx_buffer_q <= rx_shift_q; // R5
                rx_state_q  <= ST_IDLE;
              end
            end
          end
        default:
          rx_state_q <= ST_IDLE;
      endcase
    end
  end

endmodule : half_duplex_uart

// ---- verification/half_duplex_uart_monitor.sv ----
// Port-level assertions for the half-duplex serial port
`timescale 1ns/1ps
module half_duplex_uart_monitor (
  input wire logic        aclk,
  input wire logic        aresetn,
  input wire logic [7:0]  s_axi_awaddr,
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0]  s_axi_wstrb,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic [7:0]  s_axi_araddr,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic [1:0]  s_axi_rresp,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  input wire logic        rx_pin,
  input wire logic        tx_pin,
  input wire logic        rx_pull_disable
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  a_reset_idle_line: assert property (disable iff (1'b0) !aresetn |=> tx_pin &&
    !s_axi_bvalid && !s_axi_rvalid && !rx_pull_disable) else $error("bad reset state");
  a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid &&
    $stable(s_axi_bresp)) else $error("write response dropped early");
  a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid &&
    $stable(s_axi_rdata)) else $error("read data dropped early");
  a_write_answer: assert property (s_axi_awready && s_axi_wready |->
    ##[1:2] s_axi_bvalid) else $error("write response late");
  a_read_answer: assert property (s_axi_arready |-> ##[1:2] s_axi_rvalid)
    else $error("read data late");
  a_ready_pulse: assert property (s_axi_awready |=> !s_axi_awready)
    else $error("awready longer than one cycle");
  a_slverr_zero: assert property (s_axi_rvalid && s_axi_rresp == 2'b10 |->
    s_axi_rdata == 32'h0) else $error("error read returned data");
  a_resp_codes: assert property (s_axi_bvalid |-> s_axi_bresp[0] == 1'b0)
    else $error("bad write response code");
  a_pull_after_write: assert property ($changed(rx_pull_disable) |-> s_axi_bvalid ||
    $past(s_axi_bvalid) || $past(s_axi_bvalid, 2)) else $error("pull control moved alone");
endmodule : half_duplex_uart_monitor

// ---- verification/serial_partner.sv ----
// Behavioural far-side serial device: frame catcher and frame sender
`timescale 1ns/1ps
module serial_partner (
  input  wire logic       aclk,
  input  wire logic       tx_pin,
  output logic            rx_pin,
  output logic [8:0]      got_frame,
  output logic            got_strobe,
  input  var int          bit_cyc
);
  initial
  begin
    rx_pin     = 1'b1;
    got_frame  = 9'h000;
    got_strobe = 1'b0;
  end

  // Mid-bit sampling at the programmed period; tolerates a start bit a tick short
  always
  begin : catch_frame
    @(negedge tx_pin);
    repeat (bit_cyc / 2) @(negedge aclk);
    for (int i = 0; i < 9; i++)
    begin
      repeat (bit_cyc) @(negedge aclk);
      got_frame[i] = tx_pin;
    end
    got_strobe = 1'b1;
    @(negedge aclk);
    got_strobe = 1'b0;
  end

  // Caller keeps the link quiet while the device sends
  task automatic send_byte(input logic [7:0] b, input int n);
    logic [9:0] f;
    f = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      rx_pin <= f[i];
      repeat (n) @(posedge aclk);
    end
  endtask : send_byte
endmodule : serial_partner

// ---- verification/half_duplex_uart_test.sv ----
// Self-checking bench for the half-duplex serial port
`timescale 1ns/1ps
`include "uart_cfg.svh"
module half_duplex_uart_test;
  import uart_pkg::*;
  logic        aclk, aresetn, awvalid, wvalid, bready, arvalid, rready;
  logic        awready, wready, bvalid, arready, rvalid, rx_pin, tx_pin, rx_pull_disable;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [1:0]  bresp, rresp;
  logic [3:0]  wstrb;
  logic [8:0]  got_frame;
  logic        got_strobe;
  int          bit_cyc, error_cnt, total_checks, n;
  logic [33:0] rd_q[$];
  logic [8:0]  tx_q[$];
  logic [15:0] lfsr;
  logic [7:0]  b;

  half_duplex_uart i_half_duplex_uart (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_pull_disable(rx_pull_disable));
  serial_partner i_serial_partner (.aclk(aclk), .tx_pin(tx_pin), .rx_pin(rx_pin),
    .got_frame(got_frame), .got_strobe(got_strobe), .bit_cyc(bit_cyc));

  initial
  begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end

  // ****************************************
  // Comparison, bus and closing tasks
  // ****************************************
  task automatic check(input logic [33:0] seen, input logic [33:0] exp, input string what);
    total_checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("CHECK FAILED at %0t: %s", $time, what);
    end
  endtask : check

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
  endfunction : lfsr_next

  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic aw_ok, w_ok;
    aw_ok = 1'b0;
    w_ok = 1'b0;
    @(posedge aclk);
    awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1;
    while (!(aw_ok && w_ok))
    begin
      @(posedge aclk);
      if (awvalid && awready) begin awvalid <= 1'b0; aw_ok = 1'b1; end
      if (wvalid && wready) begin wvalid <= 1'b0; w_ok = 1'b1; end
    end
    // Bready rises in the same cycle as bvalid, so the response is never seen standing
    @(posedge aclk);
    bready <= 1'b1;
    do @(posedge aclk); while (bvalid !== 1'b1);
    bready <= 1'b0;
    check(34'(bresp), 34'(er), "write response");
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [1:0] er, input logic [31:0] ed);
    rd_q.push_back({er, ed});
    @(posedge aclk);
    araddr <= a; arvalid <= 1'b1;
    do @(posedge aclk); while (arready !== 1'b1);
    arvalid <= 1'b0;
    @(posedge aclk);
    rready <= 1'b1;
    do @(posedge aclk); while (rvalid !== 1'b1);
    rready <= 1'b0;
  endtask : rd

  task automatic complete_run();
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run

  always @(posedge aclk)
    if (rvalid === 1'b1 && rready === 1'b1)
      check({rresp, rdata}, rd_q.pop_front(), "read result");

  always @(posedge got_strobe)
    if (tx_q.size() == 0) check(34'(got_frame), 34'h3ffffffff, "unexpected frame");
    else check(34'(got_frame), 34'(tx_q.pop_front()), "serial frame");

  initial
  begin
    repeat (90000) @(posedge aclk);
    error_cnt++;
    complete_run();
  end

  // ****************************************
  // Scenarios
  // ****************************************
  initial
  begin
    aresetn = 1'b0; awvalid = 1'b0; wvalid = 1'b0; bready = 1'b0; arvalid = 1'b0;
    rready = 1'b0; awaddr = 8'h00; araddr = 8'h00; wdata = 32'h0; lfsr = 16'hecc0;
    wstrb = 4'hf;
    // Prescale 1, reload 1, step 0x80
    bit_cyc = `OVERSAMPLE * 32'h2 * `FRAC_MODULUS / 32'h80;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h0);
    rd(`OFF_BAUD_RELOAD_REG, 2'b00, {24'h0, `RST_BAUD_RELOAD});
    rd(`OFF_FRAC_STEP, 2'b00, {24'h0, `RST_FRAC_STEP});
    check(34'(tx_pin), 34'h1, "idle line");
    rd(8'h40, 2'b10, 32'h0);
    rd(8'h02, 2'b10, 32'h0);
    wr(8'h40, 32'h1, 2'b10);
    // Lane 0 masked: the write must not land
    wstrb <= 4'h0;
    wr(`OFF_FRAC_STEP, 32'h55, 2'b00);
    wstrb <= 4'hf;
    rd(`OFF_FRAC_STEP, 2'b00, {24'h0, `RST_FRAC_STEP});
    $display("reset and address tests done");
    wr(`OFF_GENERAL_CONFIG, 32'h1, 2'b00);
    repeat (2) @(posedge aclk);
    check(34'(rx_pull_disable), 34'h1, "pull not released");
    wr(`OFF_SERIAL_CLOCK_CONFIG, 32'h3, 2'b00);
    wr(`OFF_BAUD_CONTROL, 32'h1, 2'b00);
    rd(`OFF_BAUD_CONTROL, 2'b00, 32'h1);
    wr(`OFF_BAUD_RELOAD_REG, 32'h1, 2'b00);
    wr(`OFF_FRAC_DIV_CONTROL, 32'h1, 2'b00);
    wr(`OFF_FRAC_STEP, 32'h80, 2'b00);
    wr(`OFF_SERIAL_CONTROL, 32'h4, 2'b00);
    for (int i = 0; i < 4; i++)
    begin
      if (i == 3)
      begin
        // Last frame at the standard 115200 setting
        wr(`OFF_BAUD_RELOAD_REG, 32'h5, 2'b00);
        wr(`OFF_FRAC_STEP, 32'hec, 2'b00);
        rd(`OFF_FRAC_STEP, 2'b00, 32'hec);
        bit_cyc = `OVERSAMPLE * 32'h6 * `FRAC_MODULUS / 32'hec;
      end
      lfsr = lfsr_next(lfsr);
      b = (i == 0) ? 8'ha5 : (lfsr[7:0] | 8'h01);
      tx_q.push_back({1'b1, b});
      wr(`OFF_SERIAL_BUFFER, {24'h0, b}, 2'b00);
      @(posedge got_strobe);
      repeat (bit_cyc + 4) @(posedge aclk);
      rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h6);
      rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h6);
      wr(`OFF_SERIAL_CONTROL, 32'h4, 2'b00);
      rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h4);
    end
    $display("transmit test done");
    wr(`OFF_SERIAL_CLOCK_CONFIG, 32'h1, 2'b00);
    wr(`OFF_SERIAL_BUFFER, 32'h55, 2'b00);
    n = 0;
    repeat (300) begin @(posedge aclk); if (tx_pin !== 1'b1) n++; end
    check(34'(n), 34'h0, "sent with clock off");
    rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h4);
    wr(`OFF_SERIAL_CLOCK_CONFIG, 32'h3, 2'b00);
    i_serial_partner.send_byte(8'h3c, bit_cyc);
    repeat (10) @(posedge aclk);
    rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h5);
    fork
      i_serial_partner.send_byte(8'hc3, bit_cyc);
      begin repeat (3 * bit_cyc) @(posedge aclk); rd(`OFF_SERIAL_BUFFER, 2'b00, 32'h3c); end
    join
    repeat (10) @(posedge aclk);
    rd(`OFF_SERIAL_BUFFER, 2'b00, 32'hc3);
    wr(`OFF_SERIAL_CONTROL, 32'h0, 2'b00);
    rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h0);
    i_serial_partner.send_byte(8'h99, bit_cyc);
    repeat (10) @(posedge aclk);
    rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h0);
    rd(`OFF_SERIAL_BUFFER, 2'b00, 32'hc3);
    $display("receive test done");
    wr(`OFF_FRAC_DIV_CONTROL, 32'h0, 2'b00);
    rd(`OFF_FRAC_DIV_RESULT, 2'b00, 32'h0);
    // No ticks: the line parks at the start level and reads as an all-zero frame
    tx_q.push_back(9'h000);
    wr(`OFF_SERIAL_BUFFER, 32'h0f, 2'b00);
    repeat (12 * bit_cyc) @(posedge aclk);
    rd(`OFF_SERIAL_CONTROL, 2'b00, 32'h0);
    $display("divider enable test done");
    complete_run();
  end
endmodule : half_duplex_uart_test

bind half_duplex_uart half_duplex_uart_monitor i_half_duplex_uart_monitor (.aclk(aclk),
  .aresetn(aresetn), .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid),
  .s_axi_awready(s_axi_awready), .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bresp(s_axi_bresp),
  .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_araddr(s_axi_araddr),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
  .s_axi_rresp(s_axi_rresp), .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
  .rx_pin(rx_pin), .tx_pin(tx_pin), .rx_pull_disable(rx_pull_disable));
